/* File: src/rtr_pkg.sv */
// package for the result and trigger-mask register slice
// assumes one 100 MHz clock and an AHB-Lite register bus
package rtr_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned RES_W      = 16;
  localparam int unsigned NUM_RES_CH = 4;
  localparam int unsigned NUM_OUTS   = 2;
  localparam int unsigned NUM_IN_CH  = 8;

  // register indices; byte address is four times the index
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W   = 8;
  localparam int unsigned ADDR_HI = IDX_LSB + IDX_W;
  localparam logic [7:0] IDX_CH4_LOW   = 8'ha8;
  localparam logic [7:0] IDX_CH4_HIGH  = 8'ha9;
  localparam logic [7:0] IDX_CH5_LOW   = 8'haa;
  localparam logic [7:0] IDX_CH5_HIGH  = 8'hab;
  localparam logic [7:0] IDX_CH6_LOW   = 8'hac;
  localparam logic [7:0] IDX_CH6_HIGH  = 8'had;
  localparam logic [7:0] IDX_CH7_LOW   = 8'hae;
  localparam logic [7:0] IDX_CH7_HIGH  = 8'haf;
  localparam logic [7:0] IDX_OUT0_MASK = 8'hc3;
  localparam logic [7:0] IDX_OUT1_MASK = 8'hc5;

  localparam logic [7:0]  MASK_RESET   = 8'h02;
  localparam logic [7:0]  RESULT_RESET = 8'h00;
  localparam logic [2:0]  FIRST_CH     = 3'h4;
  localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;
  localparam logic        HRESP_OKAY   = 1'b0;

  typedef enum logic [2:0] {
    RTR_IDLE  = 3'b001,
    RTR_WRITE = 3'b010,
    RTR_READ  = 3'b100
  } rtr_phase_e;

  // one finished conversion from the converter
  typedef struct packed {
    logic             valid;
    logic [2:0]       channel;
    logic [RES_W-1:0] value;
  } rtr_conv_s;

  typedef struct packed {
    logic [BYTE_W-1:0] high;
    logic [BYTE_W-1:0] low;
  } rtr_result_s;

  typedef struct packed {
    rtr_result_s [NUM_RES_CH-1:0] res;
  } rtr_store_st_s;

  typedef struct packed {
    logic [NUM_IN_CH-1:0] mask;
    logic                 fire;
  } rtr_gate_st_s;

  typedef struct packed {
    rtr_phase_e       phase;
    logic [IDX_W-1:0] idx;
    logic             hit;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
  } rtr_bus_st_s;

endpackage

/* File: src/rtr_result_store.sv */
// latest result bytes for analog channels 4 to 7
// assumes conversions arrive as one-cycle valid strobes
`timescale 1ns/1ps
`default_nettype none
module rtr_result_store (
  // clock and reset
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  // conversion in
  input  wire rtr_pkg::rtr_conv_s                     conv,
  // stored results
  output var  rtr_pkg::rtr_result_s [rtr_pkg::NUM_RES_CH-1:0] results
);
  import rtr_pkg::*;

  rtr_store_st_s st_q;
  rtr_store_st_s st_d;
  logic          take;
  logic [1:0]    slot;

  assign take = conv.valid && (conv.channel >= FIRST_CH);
  assign slot = 2'(conv.channel - FIRST_CH);

  always_comb begin
    st_d = st_q;
    // both bytes load on one edge so the stored pair is never torn
    if (take) begin
      st_d.res[slot].high = conv.value[RES_W-1 -: BYTE_W]; // RULE_01
      st_d.res[slot].low  = conv.value[BYTE_W-1:0];        // RULE_02
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q.res <= {(2 * NUM_RES_CH){RESULT_RESET}};
    end else begin
      st_q <= st_d; // RULE_08
    end
  end

  assign results = st_q.res;

  ////////////////////////////////////////////////////////////////////////
  AST_HIGH_BYTE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    take |=> st_q.res[$past(slot)].high == $past(conv.value[RES_W-1 -: BYTE_W]))
    else $error("high byte not the top of the result");
  AST_LOW_BYTE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    take |=> st_q.res[$past(slot)].low == $past(conv.value[BYTE_W-1:0]))
    else $error("low byte not the next bits of the result");
  AST_COHERENT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
    $changed(st_q) |-> $past(take))
    else $error("result bytes changed without a conversion");
endmodule // rtr_result_store
`default_nettype wire

/* File: src/rtr_trigger_gate.sv */
// trigger mask for one general output and its gated alert event
// assumes alert flags are synchronous levels, one per input channel
`timescale 1ns/1ps
`default_nettype none
module rtr_trigger_gate (
  // clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // mask write
  input  wire logic                          wr_en,
  input  wire logic [rtr_pkg::BYTE_W-1:0]    wdata,
  // alerts and event
  input  wire logic [rtr_pkg::NUM_IN_CH-1:0] alert,
  output var  logic [rtr_pkg::NUM_IN_CH-1:0] mask,
  output var  logic                          fire
);
  import rtr_pkg::*;

  rtr_gate_st_s st_q;
  rtr_gate_st_s st_d;

  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.mask = wdata; // RULE_04
    end
    // cleared bits drop their alerts, set bits pass them
    st_d.fire = |(alert & st_q.mask); // RULE_05 RULE_06
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q.mask <= MASK_RESET; // RULE_07
      st_q.fire <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign mask = st_q.mask;
  assign fire = st_q.fire;

  ////////////////////////////////////////////////////////////////////////
  AST_MASK_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    wr_en |=> mask == $past(wdata))
    else $error("mask write lost");
  AST_MASK_IGNORE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    ((alert & mask) == '0) |=> !fire)
    else $error("masked alert fired the output");
  AST_MASK_PASS: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    ((alert & mask) != '0) |=> fire)
    else $error("enabled alert did not fire the output");
  AST_MASK_RESET: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    !$past(hresetn) |-> mask == MASK_RESET)
    else $error("mask not at reset value");
endmodule // rtr_trigger_gate
`default_nettype wire

/* File: src/rtr_regs.sv */
// result and trigger-mask register slice behind an AHB-Lite slave
// assumes a single AHB-Lite master, word transfers, one 100 MHz clock
//
// Overview of operation
// RULE_01: each channel's high result byte holds the top eight bits of its latest result, read-only, reset zero.
// RULE_02: each channel's low result byte holds the next eight bits of that result, read-only, reset zero.
// RULE_03: low and high bytes sit at consecutive indices, low first, channel 5 at 0xaa and 0xab, up to 0xaf.
// RULE_04: each general output has an eight-bit mask, one bit per input channel 7 to 0.
// RULE_05: a cleared mask bit keeps that channel's alerts from updating the output.
// RULE_06: a set mask bit lets that channel's alerts update the output.
// RULE_07: both masks reset to 0x02 and are read/write at indices 0xc3 and 0xc5.
// RULE_08: both bytes of a channel update together when a new conversion lands.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rtr_regs (
  // clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output var  logic [31:0]                   hrdata,
  output var  logic                          hreadyout,
  output var  logic                          hresp,
  // converter results
  input  wire rtr_pkg::rtr_conv_s            conv,
  // alert flags and output events
  input  wire logic [rtr_pkg::NUM_IN_CH-1:0] alert,
  output var  logic [rtr_pkg::NUM_OUTS-1:0]  out_trigger
);
  import rtr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  rtr_bus_st_s                    st_q;
  rtr_bus_st_s                    st_d;
  rtr_result_s [NUM_RES_CH-1:0]   results;
  logic [NUM_OUTS-1:0][NUM_IN_CH-1:0] mask;
  logic [NUM_OUTS-1:0][NUM_IN_CH-1:0] mask_now;
  logic [NUM_OUTS-1:0]            mask_wr;
  logic [NUM_OUTS-1:0][IDX_W-1:0] mask_idx;
  logic                           addr_ph;
  logic [IDX_W-1:0]               idx_a;
  logic                           hit_a;
  logic [BYTE_W-1:0]              rd_byte;

  assign mask_idx[0] = IDX_OUT0_MASK;
  assign mask_idx[1] = IDX_OUT1_MASK;

  // only word-aligned addresses in the low window decode; hsize is
  // not checked because the master issues whole words only
  assign addr_ph = hsel && hready && htrans[1];
  assign idx_a   = haddr[ADDR_HI-1:IDX_LSB];
  assign hit_a   = (haddr[31:ADDR_HI] == '0) && (haddr[IDX_LSB-1:0] == '0);

  ////////////////////////////////////////////////////////////////////////
  rtr_result_store u_store (
    .hclk    (hclk),
    .hresetn (hresetn),
    .conv    (conv),
    .results (results)
  );

  for (genvar k = 0; k < NUM_OUTS; k++) begin : g_out
    assign mask_wr[k] = (st_q.phase == RTR_WRITE) && st_q.hit
                        && (st_q.idx == mask_idx[k]);
    // a read right behind a write to the same mask sees the new value
    assign mask_now[k] = mask_wr[k] ? hwdata[BYTE_W-1:0] : mask[k];
    rtr_trigger_gate u_gate (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (mask_wr[k]),
      .wdata   (hwdata[BYTE_W-1:0]),
      .alert   (alert),
      .mask    (mask[k]),
      .fire    (out_trigger[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_byte = RESULT_RESET;
    if (hit_a) begin
      case (idx_a)
        IDX_CH4_LOW:   rd_byte = results[0].low;  // RULE_03
        IDX_CH4_HIGH:  rd_byte = results[0].high; // RULE_03
        IDX_CH5_LOW:   rd_byte = results[1].low;  // RULE_03
        IDX_CH5_HIGH:  rd_byte = results[1].high; // RULE_03
        IDX_CH6_LOW:   rd_byte = results[2].low;  // RULE_03
        IDX_CH6_HIGH:  rd_byte = results[2].high; // RULE_03
        IDX_CH7_LOW:   rd_byte = results[3].low;  // RULE_03
        IDX_CH7_HIGH:  rd_byte = results[3].high; // RULE_03
        IDX_OUT0_MASK: rd_byte = mask_now[0];     // RULE_07
        IDX_OUT1_MASK: rd_byte = mask_now[1];     // RULE_07
        default:       rd_byte = RESULT_RESET;
      endcase
    end
  end

  always_comb begin
    st_d           = st_q;
    st_d.hreadyout = 1'b1;
    st_d.hresp     = HRESP_OKAY;
    // read data is registered at the address edge: zero wait states
    if (addr_ph) begin
      st_d.idx = idx_a;
      st_d.hit = hit_a;
      case (hwrite)
        1'b1: begin
          st_d.phase  = RTR_WRITE;
          st_d.hrdata = RDATA_ZERO;
        end
        default: begin
          st_d.phase  = RTR_READ;
          st_d.hrdata = {{(32 - BYTE_W){1'b0}}, rd_byte};
        end
      endcase
    end else begin
      st_d.phase = RTR_IDLE;
      st_d.hit   = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q.phase     <= RTR_IDLE;
      st_q.idx       <= '0;
      st_q.hit       <= 1'b0;
      st_q.hrdata    <= RDATA_ZERO;
      st_q.hreadyout <= 1'b1;
      st_q.hresp     <= HRESP_OKAY;
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata    = st_q.hrdata;
  assign hreadyout = st_q.hreadyout;
  assign hresp     = st_q.hresp;

  ////////////////////////////////////////////////////////////////////////
  AST_CH5_LOW_MAP: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    (addr_ph && !hwrite && hit_a && idx_a == IDX_CH5_LOW)
    |=> hrdata == {24'h00_0000, $past(results[1].low)})
    else $error("channel 5 low byte not at its index");
  AST_CH7_HIGH_MAP: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    (addr_ph && !hwrite && hit_a && idx_a == IDX_CH7_HIGH)
    |=> hrdata == {24'h00_0000, $past(results[3].high)})
    else $error("channel 7 high byte not at its index");
  AST_MASK1_READ: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    (addr_ph && !hwrite && hit_a && idx_a == IDX_OUT1_MASK && !mask_wr[1])
    |=> hrdata == {24'h00_0000, $past(mask[1])})
    else $error("output 1 mask not readable at its index");
  AST_RO_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (st_q.phase == RTR_WRITE && !conv.valid) |=> $stable(results))
    else $error("bus write changed a read-only result");
  AST_ZERO_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && hresp == HRESP_OKAY)
    else $error("slave stalled or did not answer okay");
endmodule // rtr_regs
`default_nettype wire

/* File: verif/rtr_regs_tb.sv */
// self-checking bench for the result and trigger-mask register slice
// assumes rtr_regs answers with zero wait states and hready tied to hreadyout
`timescale 1ns/1ps
`default_nettype none
module rtr_regs_tb;
  import rtr_pkg::*;
  logic        hclk        = 1'b0;
  logic        hresetn     = 1'b0;
  logic        hsel        = 1'b1;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  rtr_conv_s   conv        = '0;
  logic [7:0]  alert       = 8'h0;
  logic [1:0]  out_trigger;
  logic        rd_dp       = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] trg_q[$];
  int          failures    = 0;
  int          cmp_count   = 0;
  int          seed        = 61427;
  logic [7:0]  m0;
  logic [7:0]  m1;
  logic [15:0] res [4]     = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [7:0]  idx_tab [8] = '{IDX_CH4_LOW, IDX_CH4_HIGH, IDX_CH5_LOW, IDX_CH5_HIGH,
                               IDX_CH6_LOW, IDX_CH6_HIGH, IDX_CH7_LOW, IDX_CH7_HIGH};

  always #5 hclk = ~hclk;
  // single slave, so its own ready closes the loop
  assign hready = hreadyout;

  rtr_regs u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv(conv), .alert(alert),
    .out_trigger(out_trigger)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // bounded wait so a stuck slave cannot hang the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("wrong value at %0t: bus answer timed out", $time);
      conclude();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rd_dp  <= !wr;
    wait_rdy();
    rd_dp  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h0, exp});
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic chk_res;
    for (int k = 0; k < 4; k++) begin
      rd(idx_tab[2*k], res[k][7:0]);
      rd(idx_tab[2*k+1], res[k][15:8]);
    end
  endtask

  task automatic cnv(input logic [2:0] ch, input logic [15:0] v);
    @(posedge hclk);
    conv <= '{valid: 1'b1, channel: ch, value: v};
    @(posedge hclk);
    conv <= '0;
  endtask

  // alert sampled one edge after it is driven, trigger visible right after that same edge
  task automatic trig(input logic [7:0] a);
    @(posedge hclk);
    alert <= a;
    @(posedge hclk);
    trg_q.push_back({30'h0, |(a & m1), |(a & m0)});
    @(negedge hclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
      check(hrdata, exp_q.pop_front(), "read data");
      check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
    end
  end

  // trigger level settles after the edge that samples the alert
  always @(negedge hclk) begin
    if (trg_q.size() > 0) begin
      check({30'h0, out_trigger}, trg_q.pop_front(), "trigger");
    end
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    m0 = MASK_RESET;
    m1 = MASK_RESET;
    chk_res();
    rd(IDX_OUT0_MASK, MASK_RESET);
    rd(IDX_OUT1_MASK, MASK_RESET);
    trig(8'h02);
    trig(8'hfd);
    for (int c = 4; c < 8; c++) begin
      res[c-4] = 16'($random(seed));
      cnv(3'(c), res[c-4]);
    end
    chk_res();
    // low channels, result writes and unmapped writes must all leave results alone
    cnv({1'b0, 2'($random(seed))}, 16'($random(seed)));
    bus(1'b1, IDX_CH5_HIGH, 32'($random(seed)));
    bus(1'b1, 8'hc4, 32'hffff_ffff);
    rd(8'hc4, 8'h00);
    chk_res();
    for (int r = 0; r < 6; r++) begin
      m0 = 8'($random(seed));
      m1 = 8'($random(seed));
      bus(1'b1, IDX_OUT0_MASK, {24'($random(seed)), m0});
      bus(1'b1, IDX_OUT1_MASK, {24'($random(seed)), m1});
      rd(IDX_OUT0_MASK, m0);
      rd(IDX_OUT1_MASK, m1);
      for (int b = 0; b < 8; b++) trig(8'h01 << b);
      trig(8'($random(seed)));
    end
    // reset in mid-run brings masks and results back to defaults
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    m0 = MASK_RESET;
    m1 = MASK_RESET;
    res = '{16'h0, 16'h0, 16'h0, 16'h0};
    rd(IDX_OUT0_MASK, MASK_RESET);
    rd(IDX_OUT1_MASK, MASK_RESET);
    chk_res();
    trig(8'h02);
    repeat (3) @(posedge hclk);
    conclude();
  end
endmodule // rtr_regs_tb
`default_nettype wire
